// ===== src/psd_pkg.sv
// packed simd datapath: shared constants, opcode fields and enums
// assumes one core clock; imported whole by every design file
package psd_pkg;
  localparam int NUM_REGS = 8;
  localparam int IDX_W = 3;
  localparam int DATA_W = 64;
  localparam int HALF_W = 32;
  localparam int OPC_W = 6;
  localparam int KIND_LSB = 2; // opcode is {kind, size}
  localparam int NUM_INSN = 57; // 64 codes less 7 unused ones
  localparam int NUM_SIZES = 4;
  localparam int BYTE_W = 8;
  localparam logic [7:0] BE_QUAD = 8'hff;
  localparam logic [7:0] BE_DWORD = 8'h0f;
  localparam logic [7:0] BE_RST = 8'h00;
  localparam logic [7:0] TAG_RST = 8'h00;
  localparam logic [63:0] DATA_RST = 64'h0;
  localparam logic [31:0] HALF_ZERO = 32'h0;

  typedef enum logic [1:0] {
    SZ_B = 2'b00,
    SZ_W = 2'b01,
    SZ_D = 2'b10,
    SZ_Q = 2'b11
  } psd_size_e;

  // size Q of K_UNPK is the empty-state instruction
  typedef enum logic [3:0] {
    K_LOAD = 4'b0000,
    K_STORE = 4'b0001,
    K_MOVE = 4'b0010,
    K_ADD = 4'b0011,
    K_ADDS = 4'b0100,
    K_ADDUS = 4'b0101,
    K_SUB = 4'b0110,
    K_SUBS = 4'b0111,
    K_SUBUS = 4'b1000,
    K_CMPEQ = 4'b1001,
    K_CMPGT = 4'b1010,
    K_AND = 4'b1011,
    K_OR = 4'b1100,
    K_XOR = 4'b1101,
    K_ANDN = 4'b1110,
    K_UNPK = 4'b1111
  } psd_kind_e;
endpackage

// ===== src/psd_rf_if.sv
// packed simd datapath: bundle between control and the register array
// assumes both ends run on the core clock
`timescale 1ns/1ps
interface psd_rf_if;
  import psd_pkg::*;
  logic [IDX_W-1:0] ra_idx;
  logic [IDX_W-1:0] rb_idx;
  logic [IDX_W-1:0] rf_idx;
  logic [DATA_W-1:0] ra_data;
  logic [DATA_W-1:0] rb_data;
  logic [DATA_W-1:0] rf_data;
  logic we_a;
  logic [IDX_W-1:0] wa_idx;
  logic [DATA_W-1:0] wa_data;
  logic we_f;
  logic [IDX_W-1:0] wf_idx;
  logic [DATA_W-1:0] wf_data;

  modport ctrl (output ra_idx, rb_idx, rf_idx, we_a, wa_idx, wa_data, we_f, wf_idx,
    wf_data, input ra_data, rb_data, rf_data);
  modport mem (input ra_idx, rb_idx, rf_idx, we_a, wa_idx, wa_data, we_f, wf_idx,
    wf_data, output ra_data, rb_data, rf_data);
endinterface

// ===== src/psd_regfile.sv
// packed simd datapath: eight-entry shared register array
// assumes one packed write port, one stack write port, three registered reads
`timescale 1ns/1ps
module psd_regfile import psd_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_b_i,
  psd_rf_if.mem rf
);
  logic [DATA_W-1:0] mem [NUM_REGS];
  logic [DATA_W-1:0] ra_next;
  logic [DATA_W-1:0] rb_next;
  logic [DATA_W-1:0] rf_next;
  logic [DATA_W-1:0] ra_reg;
  logic [DATA_W-1:0] rb_reg;
  logic [DATA_W-1:0] rf_reg;
  logic f_blocked_w;

  // write-first read: a reader in the writing cycle sees the new value
  function automatic logic [DATA_W-1:0] fwd(input logic [IDX_W-1:0] idx);
    fwd = mem[idx];
    if (rf.we_f && !f_blocked_w && rf.wf_idx == idx) fwd = rf.wf_data;
    if (rf.we_a && rf.wa_idx == idx) fwd = rf.wa_data;
  endfunction

  // packed result wins when both views write one entry
  assign f_blocked_w = rf.we_a && rf.wa_idx == rf.wf_idx;
  assign ra_next = fwd(rf.ra_idx);
  assign rb_next = fwd(rf.rb_idx);
  assign rf_next = fwd(rf.rf_idx);

  // one array behind both views, so either write shows through the other
  always_ff @(posedge clk_i) begin
    if (rf.we_a) mem[rf.wa_idx] <= rf.wa_data;
    if (rf.we_f && !f_blocked_w) mem[rf.wf_idx] <= rf.wf_data;
  end

  // read data leave from registers
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      ra_reg <= DATA_RST;
      rb_reg <= DATA_RST;
      rf_reg <= DATA_RST;
    end else begin
      ra_reg <= ra_next;
      rb_reg <= rb_next;
      rf_reg <= rf_next;
    end
  end

  assign rf.ra_data = ra_reg;
  assign rf.rb_data = rb_reg;
  assign rf.rf_data = rf_reg;
endmodule // psd_regfile

// ===== src/psd_lane_alu.sv
// packed simd datapath: one lane of integer arithmetic, compare and logic
// assumes the caller slices operands; nothing leaves the lane
`timescale 1ns/1ps
module psd_lane_alu import psd_pkg::*; #(
  parameter int W = 8
) (
  input psd_kind_e kind_i,
  input wire logic [W-1:0] a_i,
  input wire logic [W-1:0] b_i,
  output logic [W-1:0] y_o
);
  logic [W:0] sum_w;
  logic [W:0] dif_w;
  logic sov_w;
  logic dov_w;
  logic [W-1:0] smax_w;
  logic [W-1:0] smin_w;
  logic [W-1:0] sat_w;

  // carry and borrow land in bit W of this lane only
  assign sum_w = {1'b0, a_i} + {1'b0, b_i};
  assign dif_w = {1'b0, a_i} - {1'b0, b_i};
  assign sov_w = (a_i[W-1] == b_i[W-1]) && (sum_w[W-1] != a_i[W-1]);
  assign dov_w = (a_i[W-1] != b_i[W-1]) && (dif_w[W-1] != a_i[W-1]);
  assign smax_w = {1'b0, {(W-1){1'b1}}};
  assign smin_w = {1'b1, {(W-1){1'b0}}};
  assign sat_w = a_i[W-1] ? smin_w : smax_w; // signed overflow follows a's sign

  // signed or unsigned reading is chosen by the kind alone
  always_comb begin
    case (kind_i)
      K_ADD: y_o = sum_w[W-1:0];
      K_ADDS: y_o = sov_w ? sat_w : sum_w[W-1:0];
      K_ADDUS: y_o = sum_w[W] ? '1 : sum_w[W-1:0];
      K_SUB: y_o = dif_w[W-1:0];
      K_SUBS: y_o = dov_w ? sat_w : dif_w[W-1:0];
      K_SUBUS: y_o = dif_w[W] ? '0 : dif_w[W-1:0];
      K_CMPEQ: y_o = (a_i == b_i) ? '1 : '0;
      K_CMPGT: y_o = ($signed(a_i) > $signed(b_i)) ? '1 : '0;
      K_AND: y_o = a_i & b_i;
      K_OR: y_o = a_i | b_i;
      K_XOR: y_o = a_i ^ b_i;
      K_ANDN: y_o = ~a_i & b_i;
      default: y_o = '0;
    endcase
  end
endmodule // psd_lane_alu

// ===== src/psd_datapath.sv
// packed simd datapath: decode, operand fetch, lane execute and writeback
// assumes decode and load/store logic on the core clock; one op per cycle
`timescale 1ns/1ps
module psd_datapath import psd_pkg::*; (
  input wire logic CLK_SYS_I,
  input wire logic RST_B_I,
  input wire logic OP_VALID_I,
  input wire logic [OPC_W-1:0] OP_CODE_I,
  input wire logic [IDX_W-1:0] OP_DST_I,
  input wire logic [IDX_W-1:0] OP_SRC_I,
  input wire logic OP_EXT_I,
  input wire logic [DATA_W-1:0] EXT_DATA_I,
  input wire logic FP_WR_I,
  input wire logic [IDX_W-1:0] FP_WR_IDX_I,
  input wire logic [DATA_W-1:0] FP_WR_DATA_I,
  input wire logic [IDX_W-1:0] FP_RD_IDX_I,
  output logic RES_VALID_O,
  output logic [DATA_W-1:0] RES_DATA_O,
  output logic [7:0] RES_BE_O,
  output logic OP_ILLEGAL_O,
  output logic [DATA_W-1:0] FP_RD_DATA_O,
  output logic [NUM_REGS-1:0] FP_TAG_VALID_O
);
  psd_rf_if rf_bus ();

  psd_kind_e op_kind_w;
  psd_size_e op_size_w;
  logic op_illegal_w;
  logic op_take_w;
  logic s1_valid_reg;
  psd_kind_e s1_kind_reg;
  psd_size_e s1_size_reg;
  logic [IDX_W-1:0] s1_dst_reg;
  logic s1_ext_reg;
  logic [DATA_W-1:0] s1_ext_data_reg;
  logic [DATA_W-1:0] op_a_w;
  logic [DATA_W-1:0] op_b_w;
  wire [DATA_W-1:0] lane_res_w [NUM_SIZES];
  logic [DATA_W-1:0] alu_res_w;
  logic [DATA_W-1:0] unpk_res_w;
  logic [DATA_W-1:0] wb_data_w;
  logic wb_en_w;
  logic empty_packed_state_w;
  logic store_w;
  logic half_w;
  logic res_valid_reg;
  logic [DATA_W-1:0] res_data_reg;
  logic [DATA_W-1:0] res_data_next;
  logic [7:0] res_be_reg;
  logic illegal_reg;
  logic [NUM_REGS-1:0] tag_reg;
  logic [NUM_REGS-1:0] tag_next;

  // interleave low halves of a and b, element width picked by size
  function automatic logic [DATA_W-1:0] unpack_lo(input logic [DATA_W-1:0] a,
      input logic [DATA_W-1:0] b, input psd_size_e sz);
    int w;
    int j;
    w = BYTE_W << sz;
    unpack_lo = '0;
    for (int k = 0; k < DATA_W; k++) begin
      j = k / w;
      unpack_lo[k] = j[0] ? b[(j / 2) * w + k % w] : a[(j / 2) * w + k % w];
    end
  endfunction

  // decode is a pure function of the opcode; there is no mode bit
  assign op_kind_w = psd_kind_e'(OP_CODE_I[OPC_W-1:KIND_LSB]);
  assign op_size_w = psd_size_e'(OP_CODE_I[KIND_LSB-1:0]);
  // seven unused codes leave the 57 recognised ones
  assign op_illegal_w = ((op_kind_w == K_LOAD || op_kind_w == K_STORE) && !op_size_w[1])
    || (op_kind_w == K_MOVE && op_size_w != SZ_Q);
  assign op_take_w = OP_VALID_I && !op_illegal_w;

  // reads start with the request; index selects the register directly
  assign rf_bus.ra_idx = OP_DST_I;
  assign rf_bus.rb_idx = OP_SRC_I;
  assign rf_bus.rf_idx = FP_RD_IDX_I;
  assign rf_bus.we_f = FP_WR_I;
  assign rf_bus.wf_idx = FP_WR_IDX_I;
  assign rf_bus.wf_data = FP_WR_DATA_I;

  psd_regfile u_regfile (
    .clk_i(CLK_SYS_I),
    .rst_b_i(RST_B_I),
    .rf(rf_bus.mem)
  );

  // execute stage holds the taken instruction for one cycle
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I) begin
      s1_valid_reg <= 1'b0;
      s1_kind_reg <= K_LOAD;
      s1_size_reg <= SZ_B;
      s1_dst_reg <= '0;
      s1_ext_reg <= 1'b0;
      s1_ext_data_reg <= DATA_RST;
    end else begin
      s1_valid_reg <= op_take_w;
      s1_kind_reg <= op_kind_w;
      s1_size_reg <= op_size_w;
      s1_dst_reg <= OP_DST_I;
      s1_ext_reg <= OP_EXT_I;
      s1_ext_data_reg <= EXT_DATA_I;
    end
  end

  // memory operands arrive as data; addressing stays in the integer core
  assign op_a_w = rf_bus.ra_data;
  assign op_b_w = s1_ext_reg ? s1_ext_data_reg : rf_bus.rb_data;

  // one lane slice per element for every width; lane 0 always lowest bits
  generate
    for (genvar gs = 0; gs < NUM_SIZES; gs++) begin : g_size
      localparam int LW = BYTE_W << gs;
      for (genvar gl = 0; gl < DATA_W / LW; gl++) begin : g_lane
        psd_lane_alu #(.W(LW)) u_lane (
          .kind_i(s1_kind_reg),
          .a_i(op_a_w[gl * LW +: LW]),
          .b_i(op_b_w[gl * LW +: LW]),
          .y_o(lane_res_w[gs][gl * LW +: LW])
        );
      end
    end
  endgenerate

  // the instruction alone picks how the 64 bits are sliced
  assign alu_res_w = lane_res_w[s1_size_reg];
  assign unpk_res_w = unpack_lo(op_a_w, op_b_w, s1_size_reg);
  assign half_w = s1_size_reg == SZ_D;
  assign empty_packed_state_w = s1_valid_reg && s1_kind_reg == K_UNPK && s1_size_reg == SZ_Q;
  assign store_w = s1_valid_reg && s1_kind_reg == K_STORE;
  assign wb_en_w = s1_valid_reg && s1_kind_reg != K_STORE && !empty_packed_state_w;

  // writeback value per kind; quad loads and moves carry whole blocks untouched, 32-bit loads clear the upper half
  always_comb begin
    case (s1_kind_reg)
      K_LOAD: wb_data_w = half_w ? {HALF_ZERO, op_b_w[HALF_W-1:0]} : op_b_w;
      K_MOVE: wb_data_w = op_b_w;
      K_UNPK: wb_data_w = unpk_res_w;
      default: wb_data_w = alu_res_w;
    endcase
  end

  assign rf_bus.we_a = wb_en_w;
  assign rf_bus.wa_idx = s1_dst_reg;
  assign rf_bus.wa_data = wb_data_w;

  // store data keep register bit order: byte n goes to address base + n
  assign res_data_next = half_w ? {HALF_ZERO, op_a_w[HALF_W-1:0]} : op_a_w;

  // tags: packed writeback marks all full (stores do not), empty-state clears, a stack write sets one
  always_comb begin
    tag_next = tag_reg;
    if (wb_en_w) tag_next = '1;
    if (empty_packed_state_w) tag_next = TAG_RST;
    if (FP_WR_I) tag_next[FP_WR_IDX_I] = 1'b1; // a set beats the clear
  end

  // output registers
  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_B_I) begin
      res_valid_reg <= 1'b0;
      res_data_reg <= DATA_RST;
      res_be_reg <= BE_RST;
      illegal_reg <= 1'b0;
      tag_reg <= TAG_RST;
    end else begin
      res_valid_reg <= store_w;
      res_data_reg <= res_data_next;
      res_be_reg <= half_w ? BE_DWORD : BE_QUAD;
      illegal_reg <= OP_VALID_I && op_illegal_w;
      tag_reg <= tag_next;
    end
  end

  assign RES_VALID_O = res_valid_reg;
  assign RES_DATA_O = res_data_reg;
  assign RES_BE_O = res_be_reg;
  assign OP_ILLEGAL_O = illegal_reg;
  assign FP_RD_DATA_O = rf_bus.rf_data;
  assign FP_TAG_VALID_O = tag_reg;

  // independent references for the checks below
  logic [HALF_W-1:0] ext_lo_w;
  logic [7:0] byte1_sum_w;
  logic [15:0] word1_sum_w;
  assign ext_lo_w = EXT_DATA_I[HALF_W-1:0];
  assign byte1_sum_w = 8'(op_a_w[15:8] + op_b_w[15:8]);
  assign word1_sum_w = 16'(op_a_w[31:16] + op_b_w[31:16]);

  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RST_B_I);

  sequence s_packed_wr;
    rf_bus.we_a ##1 (FP_RD_IDX_I == $past(rf_bus.wa_idx) && !rf_bus.we_a && !FP_WR_I);
  endsequence

  a_load32_clear: assert property (
    op_take_w && op_kind_w == K_LOAD && op_size_w == SZ_D && OP_EXT_I |=>
      rf_bus.we_a && rf_bus.wa_idx == $past(OP_DST_I)
      && rf_bus.wa_data == {HALF_ZERO, $past(ext_lo_w)})
    else $error("32-bit load did not clear upper half");

  a_alias_view: assert property (s_packed_wr |=>
      FP_RD_DATA_O == $past(rf_bus.wa_data, 2))
    else $error("stack view missed packed write");

  a_store_order: assert property (
    store_w && s1_size_reg == SZ_Q |=>
      RES_VALID_O && RES_BE_O == BE_QUAD && RES_DATA_O == $past(op_a_w))
    else $error("quad store data or enables wrong");

  a_store_half: assert property (
    store_w && half_w |=> RES_VALID_O && RES_BE_O == BE_DWORD
      && RES_DATA_O[DATA_W-1:HALF_W] == HALF_ZERO)
    else $error("32-bit store enables wrong");

  a_byte_lane_add: assert property (
    s1_valid_reg && s1_kind_reg == K_ADD && s1_size_reg == SZ_B |->
      rf_bus.we_a && rf_bus.wa_data[15:8] == byte1_sum_w)
    else $error("carry leaked between byte lanes");

  a_word_by_op: assert property (
    s1_valid_reg && s1_kind_reg == K_ADD && s1_size_reg == SZ_W |->
      rf_bus.wa_data[31:16] == word1_sum_w)
    else $error("word add lane result wrong");

  a_sign_choice: assert property (
    s1_valid_reg && s1_size_reg == SZ_B && op_a_w[63:56] == 8'h7f && op_b_w[63:56] == 8'h01
      |-> (s1_kind_reg != K_ADDS || rf_bus.wa_data[63:56] == 8'h7f)
      && (s1_kind_reg != K_ADDUS || rf_bus.wa_data[63:56] == 8'h80))
    else $error("signed or unsigned byte add wrong");

  a_empty_tags: assert property (
    empty_packed_state_w && !FP_WR_I |=> FP_TAG_VALID_O == TAG_RST ##1 $stable(FP_TAG_VALID_O)
      || $past(rf_bus.we_a) || $past(FP_WR_I))
    else $error("empty-state left tags set");

  a_illegal_op: assert property (
    OP_VALID_I && op_illegal_w |=> OP_ILLEGAL_O && !s1_valid_reg)
    else $error("unused opcode not refused");

  a_quad_move: assert property (
    op_take_w && op_kind_w == K_MOVE && OP_EXT_I |=>
      rf_bus.we_a && rf_bus.wa_data == $past(EXT_DATA_I))
    else $error("quad move altered data");

  // more lane references, cut from plain slices so they do not lean on the lane units
  logic [31:0] dword1_sum_w;
  logic [7:0] byte7_dif_w;
  logic [15:0] word3_dif_w;
  logic [15:0] word0_eq_w;
  assign dword1_sum_w = 32'(op_a_w[63:32] + op_b_w[63:32]);
  assign byte7_dif_w = 8'(op_a_w[63:56] - op_b_w[63:56]);
  assign word3_dif_w = 16'(op_a_w[63:48] - op_b_w[63:48]);
  assign word0_eq_w = (op_a_w[15:0] == op_b_w[15:0]) ? 16'hffff : 16'h0000;

  // a refused code leaves no write now and no store pulse one cycle on
  sequence s_no_effect;
    !rf_bus.we_a ##1 !RES_VALID_O;
  endsequence

  // stack write naming the entry the stack view reads, with no packed write to it
  sequence s_fp_wr_self;
    FP_WR_I && FP_RD_IDX_I == FP_WR_IDX_I && !(rf_bus.we_a && rf_bus.wa_idx == FP_WR_IDX_I);
  endsequence

  a_dword_add: assert property (
    s1_valid_reg && s1_kind_reg == K_ADD && s1_size_reg == SZ_D |->
      rf_bus.we_a && rf_bus.wa_data[63:32] == dword1_sum_w)
    else $error("high doubleword lane sum wrong");

  a_byte_hi_sub: assert property (
    s1_valid_reg && s1_kind_reg == K_SUB && s1_size_reg == SZ_B |->
      rf_bus.we_a && rf_bus.wa_data[63:56] == byte7_dif_w)
    else $error("top byte lane difference wrong");

  a_word_hi_sub: assert property (
    s1_valid_reg && s1_kind_reg == K_SUB && s1_size_reg == SZ_W |->
      rf_bus.we_a && rf_bus.wa_data[63:48] == word3_dif_w)
    else $error("top word lane difference wrong");

  a_xor_lanes: assert property (
    s1_valid_reg && s1_kind_reg == K_XOR |->
      rf_bus.we_a && rf_bus.wa_data == (op_a_w ^ op_b_w))
    else $error("logic result differs across lanes");

  a_unpack_dword: assert property (
    s1_valid_reg && s1_kind_reg == K_UNPK && s1_size_reg == SZ_D |->
      rf_bus.we_a && rf_bus.wa_data == {op_b_w[HALF_W-1:0], op_a_w[HALF_W-1:0]})
    else $error("doubleword unpack order wrong");

  a_cmp_mask: assert property (
    s1_valid_reg && s1_kind_reg == K_CMPEQ && s1_size_reg == SZ_W |->
      rf_bus.we_a && rf_bus.wa_data[15:0] == word0_eq_w)
    else $error("word compare mask wrong");

  a_load_quad: assert property (
    op_take_w && op_kind_w == K_LOAD && op_size_w == SZ_Q && OP_EXT_I |=>
      rf_bus.we_a && rf_bus.wa_data == $past(EXT_DATA_I))
    else $error("quad load reordered data");

  a_illegal_quiet: assert property (
    OP_VALID_I && op_illegal_w |=> s_no_effect)
    else $error("refused code had an effect");

  a_fp_rd_fwd: assert property (
    s_fp_wr_self |=> FP_RD_DATA_O == $past(FP_WR_DATA_I))
    else $error("stack view missed same-cycle write");

  a_fp_tag_set: assert property (
    FP_WR_I |=> FP_TAG_VALID_O[$past(FP_WR_IDX_I)])
    else $error("stack write left its tag clear");
endmodule // psd_datapath

// ===== testbench/psd_store_sink.sv
// store-side partner: byte memory that takes each result of the datapath
// assumes registered store outputs; each store fills the next eight-byte slot
`timescale 1ns/1ps
module psd_store_sink import psd_pkg::*; (
  input wire logic clk_i,
  input wire logic res_valid_i,
  input wire logic [DATA_W-1:0] res_data_i,
  input wire logic [7:0] res_be_i
);
  logic [7:0] mem [2048];
  int unsigned wr_ptr;

  // fill pattern makes bytes with no enable visible as untouched
  initial begin
    foreach (mem[i]) mem[i] = 8'ha5;
    wr_ptr = 0;
  end

  // byte lane n lands at slot base plus n, no reordering
  always @(posedge clk_i) begin
    if (res_valid_i === 1'b1) begin
      for (int n = 0; n < 8; n++) begin
        if (res_be_i[n]) mem[wr_ptr + n] <= res_data_i[8*n +: 8];
      end
      wr_ptr <= wr_ptr + 8;
    end
  end
endmodule // psd_store_sink

// ===== testbench/packed_simd_register_datapath_tb.sv
// bench for the packed datapath: reference model with queues, store sink partner
// assumes the hand-over timing: writes and stores both land on the second rising edge after issue
`timescale 1ns/1ps
module packed_simd_register_datapath_tb;
  import psd_pkg::*;
  logic clk, rst_b, op_valid, op_ext, fp_wr, res_valid, op_illegal;
  logic [OPC_W-1:0] op_code;
  logic [IDX_W-1:0] op_dst, op_src, fp_wr_idx, fp_rd_idx;
  logic [DATA_W-1:0] ext_data, fp_wr_data, res_data, fp_rd_data;
  logic [7:0] res_be;
  logic [NUM_REGS-1:0] tag_valid;
  logic [63:0] rf_m [NUM_REGS];
  logic [71:0] st_q[$];
  logic [71:0] st_all[$];
  logic [63:0] one_lane [3] = '{64'h0101010101010101, 64'h0001000100010001, 64'h0000000100000001};
  int err_total, cmp_count, ill_seen, ill_exp, k, s;
  logic [31:0] rng;

  psd_datapath dut_u (.CLK_SYS_I(clk), .RST_B_I(rst_b), .OP_VALID_I(op_valid),
    .OP_CODE_I(op_code), .OP_DST_I(op_dst), .OP_SRC_I(op_src), .OP_EXT_I(op_ext),
    .EXT_DATA_I(ext_data), .FP_WR_I(fp_wr), .FP_WR_IDX_I(fp_wr_idx),
    .FP_WR_DATA_I(fp_wr_data), .FP_RD_IDX_I(fp_rd_idx), .RES_VALID_O(res_valid),
    .RES_DATA_O(res_data), .RES_BE_O(res_be), .OP_ILLEGAL_O(op_illegal),
    .FP_RD_DATA_O(fp_rd_data), .FP_TAG_VALID_O(tag_valid));
  psd_store_sink sink_u (.clk_i(clk), .res_valid_i(res_valid), .res_data_i(res_data),
    .res_be_i(res_be));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic check(input logic [71:0] seen, input logic [71:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    if (err_total == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  function automatic logic [31:0] xs_next;
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  // lane reference: longint keeps carries visible so they can be cut at the lane edge
  function automatic logic [63:0] ref_op(input int k, input int s, input logic [63:0] a,
    input logic [63:0] b);
    int w, n;
    longint x, y, z, hi, lo, m;
    logic [63:0] r;
    w = 8 << s;
    n = 64 / w;
    r = '0;
    m = (longint'(1) << w) - 1;
    hi = (longint'(1) << (w - 1)) - 1;
    lo = -hi - 1;
    case (k)
      11: return a & b;
      12: return a | b;
      13: return a ^ b;
      14: return ~a & b;
      default: ;
    endcase
    for (int i = 0; i < n; i++) begin
      if (k == 15) begin
        z = (i % 2 == 0) ? ((a >> ((i/2)*w)) & m) : ((b >> ((i/2)*w)) & m);
      end else begin
        x = (a >> (i*w)) & m;
        y = (b >> (i*w)) & m;
        if (k == 4 || k == 7 || k == 10) begin
          if (x > hi) x -= m + 1;
          if (y > hi) y -= m + 1;
        end
        case (k)
          3, 4, 5: z = x + y;
          6, 7, 8: z = x - y;
          9: z = (x == y) ? m : 0;
          default: z = (x > y) ? m : 0;
        endcase
        if (k == 4 || k == 7) z = (z > hi) ? hi : ((z < lo) ? lo : z);
        if (k == 5 && z > m) z = m;
        if (k == 8 && z < 0) z = 0;
      end
      r |= (64'(z) & 64'(m)) << (i*w);
    end
    return r;
  endfunction

  // one request per cycle; the model updates at once since the design forwards
  task automatic issue(input int k, input int s, input int d, input int src,
    input logic ex, input logic [63:0] ed);
    logic [63:0] a, b;
    @(negedge clk);
    op_valid = 1'b1;
    op_code = {4'(k), 2'(s)};
    op_dst = 3'(d);
    op_src = 3'(src);
    op_ext = ex;
    ext_data = ed;
    a = rf_m[d];
    b = ex ? ed : rf_m[src];
    if ((k < 2 && s < 2) || (k == 2 && s < 3)) ill_exp++;
    else if (k == 0) rf_m[d] = (s == 3) ? ed : {HALF_ZERO, ed[31:0]};
    else if (k == 1) begin
      st_q.push_back((s == 3) ? {BE_QUAD, a} : {BE_DWORD, HALF_ZERO, a[31:0]});
      st_all.push_back((s == 3) ? {BE_QUAD, a} : {BE_DWORD, HALF_ZERO, a[31:0]});
    end else if (k == 2) rf_m[d] = b;
    else if (!(k == 15 && s == 3)) rf_m[d] = ref_op(k, s, a, b);
  endtask

  task automatic idle(input int n);
    repeat (n) begin
      @(negedge clk);
      op_valid = 1'b0;
      fp_wr = 1'b0;
    end
  endtask

  task automatic fp_put(input int i, input logic [63:0] d);
    @(negedge clk);
    op_valid = 1'b0;
    fp_wr = 1'b1;
    fp_wr_idx = 3'(i);
    fp_wr_data = d;
    fp_rd_idx = 3'(i);
    rf_m[i] = d;
  endtask

  task automatic fp_chk(input int i);
    @(negedge clk);
    op_valid = 1'b0;
    fp_wr = 1'b0;
    fp_rd_idx = 3'(i);
    @(negedge clk);
    check(fp_rd_data, rf_m[i]);
  endtask

  // store results and refusals are checked in the cycle they stand
  always @(negedge clk) begin
    if (res_valid === 1'b1) begin
      if (st_q.size() == 0) check(72'h1, 72'h0);
      else check({res_be, res_data}, st_q.pop_front());
    end
    if (op_illegal === 1'b1) ill_seen++;
  end

  initial begin
    #2_000_000;
    err_total++;
    complete_run();
  end

  initial begin
    rng = 32'd56900;
    {op_valid, op_ext, fp_wr, op_code, op_dst, op_src, fp_wr_idx, fp_rd_idx} = '0;
    {ext_data, fp_wr_data} = '0;
    {err_total, cmp_count, ill_seen, ill_exp} = '0;
    foreach (rf_m[i]) rf_m[i] = DATA_RST;
    rst_b = 1'b0;
    repeat (6) @(negedge clk);
    rst_b = 1'b1;
    check(tag_valid, TAG_RST);
    for (int r = 0; r < 8; r++) issue(0, 3, r, 0, 1'b1, {xs_next(), xs_next()});
    for (int r = 0; r < 8; r++) issue(1, 3, r, 0, 1'b0, 64'h0);
    idle(3);
    check(tag_valid, 8'hff);
    for (int r = 0; r < 8; r++) fp_chk(r);
    // lane boundaries: max, all ones, min and zero lanes (only max and min at dword width) plus one per lane
    for (int sz = 0; sz < 3; sz++) begin
      for (int kk = 3; kk < 9; kk++) begin
        issue(0, 3, 1, 0, 1'b1, 64'h7fffffff80000000);
        issue(kk, sz, 1, 0, 1'b1, one_lane[sz]);
        issue(1, 3, 1, 0, 1'b0, 64'h0);
      end
    end
    // random traffic across kinds and lane widths, stores interleaved
    repeat (150) begin
      k = int'(xs_next() % 16);
      s = (k < 2) ? 2 + int'(xs_next() % 2) : ((k == 2) ? 3 : int'(xs_next() % 3));
      issue(k, s, int'(xs_next() % 8), int'(xs_next() % 8), (k == 0) | xs_next() % 2,
        {xs_next(), xs_next()});
      if (xs_next() % 2) issue(1, 2 + int'(xs_next() % 2), int'(xs_next() % 8), 0, 1'b0, 64'h0);
    end
    issue(0, 2, 6, 0, 1'b1, 64'hdeadbeef_12345678);
    issue(1, 3, 6, 0, 1'b0, 64'h0);
    issue(15, 3, 0, 0, 1'b0, 64'h0);
    idle(3);
    check(tag_valid, 8'h00);
    fp_put(5, {xs_next(), xs_next()});
    idle(2);
    check(tag_valid, 8'h20);
    fp_chk(5);
    issue(1, 3, 5, 0, 1'b0, 64'h0);
    for (int kk = 0; kk < 3; kk++) begin
      for (int sz = 0; sz < ((kk == 2) ? 3 : 2); sz++) issue(kk, sz, 3, 4, 1'b1, 64'h0f0f);
    end
    issue(1, 3, 3, 0, 1'b0, 64'h0);
    idle(6);
    check(ill_seen, ill_exp);
    check(st_q.size(), 0);
    check(sink_u.wr_ptr, 8 * st_all.size());
    foreach (st_all[j]) begin
      for (int n = 0; n < 8; n++) begin
        check(sink_u.mem[8*j + n], st_all[j][64+n] ? st_all[j][8*n +: 8] : 8'ha5);
      end
    end
    complete_run();
  end
endmodule // packed_simd_register_datapath_tb
